// File: core/orfc_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the output pin and FIFO threshold registers
// Assumes: Included by bare name from every design file that needs it
// Notes: Definitions only
`ifndef ORFC_DEFINES_SVH
`define ORFC_DEFINES_SVH

`define ORFC_ADDR_PIN_ONE 6'h01
`define ORFC_ADDR_PIN_ZERO 6'h02
`define ORFC_ADDR_FIFO_THR 6'h03
`define ORFC_ADDR_TEST_TWO 6'h2c
`define ORFC_ADDR_TEST_ONE 6'h2d

`define ORFC_RST_PIN_ONE 8'h2e
`define ORFC_RST_PIN_ZERO 8'h3f
`define ORFC_RST_FIFO_THR 8'h07
`define ORFC_RST_TEST_ONE 8'h00
`define ORFC_RST_TEST_TWO 8'h00

`define ORFC_BIT_DRIVE 7
`define ORFC_BIT_INVERT 6
`define ORFC_BIT_RETENTION 6
`define ORFC_ATTEN_HI 5
`define ORFC_ATTEN_LO 4
`define ORFC_SEL_HI 5
`define ORFC_THR_HI 3

`define ORFC_SEL_THREE_STATE 6'h2e
`define ORFC_SEL_XOSC_DIV 6'h3f
`define ORFC_XOSC_DIVIDE 192

`define ORFC_WAKE_T1_RET0 8'h31
`define ORFC_WAKE_T2_RET0 8'h88
`define ORFC_WAKE_T1_RET1 8'h35
`define ORFC_WAKE_T2_RET1 8'h81

`endif

// File: core/orfc_pkg.sv
// Purpose: Types shared by the configuration register files
// Assumes: Nothing beyond the defines header
// Notes: Power state is one-hot
package orfc_pkg;
    typedef enum logic [1:0] {
        ORFC_ACTIVE = 2'b01,
        ORFC_ASLEEP = 2'b10
    } orfc_power_t;
    typedef logic [7:0] orfc_byte_t;
endpackage

// File: core/orfc_regs.sv
// Purpose: Output pin and receive FIFO threshold configuration registers with their pin logic
// Assumes: Register port is the internal side of the serial configuration interface
// Notes: Read data appear one cycle after the read strobe
`timescale 1ns/1ps
`include "orfc_defines.svh"
module orfc_regs #(
    parameter int DIVIDE = `ORFC_XOSC_DIVIDE,
    parameter int FIFO_W = 7
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic [63:0] sig_src_i,
    input wire logic [FIFO_W-1:0] rx_fill_i,
    input wire logic sleep_req_i,
    input wire logic wake_i,
    output logic pin_one_o,
    output logic pin_one_oe_o,
    output logic pin_zero_o,
    output logic pin_zero_oe_o,
    output logic output_drive_strength_sel_o,
    output logic [1:0] close_in_atten_o,
    output logic threshold_met_o,
    output logic [7:0] test_setting_one_o,
    output logic [7:0] test_setting_two_o,
    output logic asleep_o
);
    localparam int HALF = DIVIDE / 2;
    localparam int CW = $clog2(HALF);

    // Below 4 the half-period counter would have no bits at all
    if (DIVIDE < 4 || (DIVIDE % 2) != 0) begin : g_bad_divide
        $error("DIVIDE must be even and at least 4");
    end
    if (FIFO_W < 7) begin : g_bad_fifo_w
        $error("FIFO_W must hold a count of 64");
    end

    orfc_pkg::orfc_byte_t pin_one_q, pin_one_d;
    orfc_pkg::orfc_byte_t pin_zero_q, pin_zero_d;
    orfc_pkg::orfc_byte_t thr_q, thr_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic [CW-1:0] div_cnt_q, div_cnt_d;
    logic div_clk_q, div_clk_d;
    logic p1_q, p1_d, p1_oe_q, p1_oe_d;
    logic p0_q, p0_d, p0_oe_q, p0_oe_d;
    logic met_q, met_d;
    logic [FIFO_W-1:0] level;
    logic [4:0] code_plus;
    logic [5:0] sel_one, sel_zero;
    logic inv_one, inv_zero;
    logic src_one, src_zero;
    logic wake_load;
    logic [7:0] int_test_one, int_test_two;

    assign sel_one = pin_one_q[`ORFC_SEL_HI:0];
    assign sel_zero = pin_zero_q[`ORFC_SEL_HI:0];
    assign inv_one = pin_one_q[`ORFC_BIT_INVERT];
    assign inv_zero = pin_zero_q[`ORFC_BIT_INVERT];

    // Register writes and reads
    always_comb begin
        pin_one_d = pin_one_q;
        pin_zero_d = pin_zero_q;
        thr_d = thr_q;
        rvalid_d = reg_rd_i;
        rdata_d = rdata_q;
        if (reg_wr_i) begin
            if (reg_addr_i == `ORFC_ADDR_PIN_ONE) begin
                pin_one_d = reg_wdata_i;
            end else if (reg_addr_i == `ORFC_ADDR_PIN_ZERO) begin
                pin_zero_d = reg_wdata_i;
            end else if (reg_addr_i == `ORFC_ADDR_FIFO_THR) begin
                thr_d = reg_wdata_i;
            end
        end
        if (reg_rd_i) begin
            if (reg_addr_i == `ORFC_ADDR_PIN_ONE) begin
                rdata_d = pin_one_q;
            end else if (reg_addr_i == `ORFC_ADDR_PIN_ZERO) begin
                rdata_d = pin_zero_q;
            end else if (reg_addr_i == `ORFC_ADDR_FIFO_THR) begin
                rdata_d = thr_q;
            end else if (reg_addr_i == `ORFC_ADDR_TEST_ONE) begin
                // Wake values stay internal; software sees only reset values
                rdata_d = `ORFC_RST_TEST_ONE;
            end else if (reg_addr_i == `ORFC_ADDR_TEST_TWO) begin
                rdata_d = `ORFC_RST_TEST_TWO;
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_one_q <= `ORFC_RST_PIN_ONE;
            pin_zero_q <= `ORFC_RST_PIN_ZERO;
            thr_q <= `ORFC_RST_FIFO_THR;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            pin_one_q <= pin_one_d;
            pin_zero_q <= pin_zero_d;
            thr_q <= thr_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // Stand-in for the crystal clock divider; the block clock is the crystal clock
    always_comb begin
        div_cnt_d = div_cnt_q + 1'b1;
        div_clk_d = div_clk_q;
        if (div_cnt_q == CW'(HALF - 1)) begin
            div_cnt_d = '0;
            div_clk_d = ~div_clk_q;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt_q <= '0;
            div_clk_q <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_d;
            div_clk_q <= div_clk_d;
        end
    end

    // Pin source selection, one cycle of latency on every source
    always_comb begin
        src_one = sig_src_i[sel_one];
        src_zero = sig_src_i[sel_zero];
        if (sel_one == `ORFC_SEL_XOSC_DIV) begin
            src_one = div_clk_q;
        end
        if (sel_zero == `ORFC_SEL_XOSC_DIV) begin
            src_zero = div_clk_q;
        end
        p1_d = src_one ^ inv_one;
        p0_d = src_zero ^ inv_zero;
        p1_oe_d = sel_one != `ORFC_SEL_THREE_STATE;
        p0_oe_d = sel_zero != `ORFC_SEL_THREE_STATE;
        // A released pin drives nothing, so its level is parked low
        if (!p1_oe_d) begin
            p1_d = 1'b0;
        end
        if (!p0_oe_d) begin
            p0_d = 1'b0;
        end
    end

    // Threshold level is four bytes per code step
    assign code_plus = {1'b0, thr_q[`ORFC_THR_HI:0]} + 5'h01;
    assign level = FIFO_W'({code_plus, 2'b00});

    always_comb begin
        met_d = rx_fill_i >= level;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            p1_q <= 1'b0;
            p1_oe_q <= 1'b0;
            p0_q <= 1'b0;
            p0_oe_q <= 1'b0;
            met_q <= 1'b0;
        end else begin
            p1_q <= p1_d;
            p1_oe_q <= p1_oe_d;
            p0_q <= p0_d;
            p0_oe_q <= p0_oe_d;
            met_q <= met_d;
        end
    end

    orfc_wake_test u_wake (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .sleep_req_i(sleep_req_i),
        .wake_i(wake_i),
        .retention_i(thr_q[`ORFC_BIT_RETENTION]),
        .asleep_o(asleep_o),
        .wake_load_o(wake_load),
        .test_one_o(int_test_one),
        .test_two_o(int_test_two)
    );

    assign reg_rdata_o = rdata_q;
    assign reg_rvalid_o = rvalid_q;
    assign pin_one_o = p1_q;
    assign pin_one_oe_o = p1_oe_q;
    assign pin_zero_o = p0_q;
    assign pin_zero_oe_o = p0_oe_q;
    // One drive strength bit serves every output pin
    assign output_drive_strength_sel_o = pin_one_q[`ORFC_BIT_DRIVE];
    // Code maps to 0, 6, 12 or 18 dB in the analogue front end
    assign close_in_atten_o = thr_q[`ORFC_ATTEN_HI:`ORFC_ATTEN_LO];
    assign threshold_met_o = met_q;
    assign test_setting_one_o = int_test_one;
    assign test_setting_two_o = int_test_two;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_drive_follows_write: assert property (
        reg_wr_i && reg_addr_i == `ORFC_ADDR_PIN_ONE |=> output_drive_strength_sel_o == $past(reg_wdata_i[7]))
        else $error("drive strength does not follow pin one write");

    a_invert_pin_one: assert property (
        p1_oe_d && sel_one != `ORFC_SEL_XOSC_DIV |=> pin_one_o == ($past(sig_src_i[sel_one]) ^ $past(inv_one)))
        else $error("pin one polarity wrong");

    a_three_state_pin: assert property (
        sel_one == `ORFC_SEL_THREE_STATE ##1 sel_one == `ORFC_SEL_THREE_STATE |-> !pin_one_oe_o)
        else $error("pin one driven while three-state selected");

    a_clock_on_zero: assert property (
        sel_zero == `ORFC_SEL_XOSC_DIV && !inv_zero && $changed(div_clk_q) ##1
            sel_zero == `ORFC_SEL_XOSC_DIV && !inv_zero |-> pin_zero_o == div_clk_q && pin_zero_oe_o)
        else $error("pin zero does not carry divided clock");

    a_wake_ret0: assert property (
        asleep_o && wake_i && !thr_q[6] |=> wake_load ##0 test_setting_one_o == 8'h31 && test_setting_two_o == 8'h88)
        else $error("wrong test values on wake without retention");

    a_wake_ret1: assert property (
        asleep_o && wake_i && thr_q[6] |=> wake_load ##0 test_setting_one_o == 8'h35 && test_setting_two_o == 8'h81)
        else $error("wrong test values on wake with retention");

    a_test_read_reset: assert property (
        reg_rd_i && reg_addr_i == `ORFC_ADDR_TEST_ONE |=> reg_rvalid_o && reg_rdata_o == `ORFC_RST_TEST_ONE)
        else $error("test register read returned non-reset value");

    a_atten_field: assert property (
        reg_wr_i && reg_addr_i == `ORFC_ADDR_FIFO_THR |=> close_in_atten_o == $past(reg_wdata_i[5:4]))
        else $error("attenuation code does not follow write");

    a_threshold_met: assert property (
        ##1 threshold_met_o == ($past(rx_fill_i) >= FIFO_W'(({4'h0, $past(thr_q[3:0])} + 8'h01) * 8'h04)))
        else $error("threshold flag wrong");

    a_invert_pin_zero: assert property (
        p0_oe_d && sel_zero != `ORFC_SEL_XOSC_DIV |=>
            pin_zero_o == ($past(sig_src_i[sel_zero]) ^ $past(inv_zero)))
        else $error("pin zero polarity wrong");

    // A released pin must not float high through the invert bit
    a_released_low: assert property (
        (pin_one_oe_o || !pin_one_o) && (pin_zero_oe_o || !pin_zero_o))
        else $error("released pin not parked low");

    a_zero_three_state: assert property (
        sel_zero == `ORFC_SEL_THREE_STATE ##1 sel_zero == `ORFC_SEL_THREE_STATE |-> !pin_zero_oe_o)
        else $error("pin zero driven while three-state selected");

    a_clock_on_one: assert property (
        sel_one == `ORFC_SEL_XOSC_DIV && !inv_one && $changed(div_clk_q) ##1
            sel_one == `ORFC_SEL_XOSC_DIV && !inv_one |-> pin_one_o == div_clk_q && pin_one_oe_o)
        else $error("pin one does not carry divided clock");

    a_drive_holds: assert property (
        !(reg_wr_i && reg_addr_i == `ORFC_ADDR_PIN_ONE) |=> $stable(output_drive_strength_sel_o))
        else $error("drive strength changed without a write");

    a_read_valid: assert property (
        1'b1 |=> reg_rvalid_o == $past(reg_rd_i))
        else $error("read valid not one cycle after read strobe");

    a_rdata_holds: assert property (
        !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");

    a_read_pin_zero: assert property (
        reg_rd_i && reg_addr_i == `ORFC_ADDR_PIN_ZERO |=> reg_rdata_o == $past(pin_zero_q))
        else $error("pin zero register read back wrong");

    a_test_two_read: assert property (
        reg_rd_i && reg_addr_i == `ORFC_ADDR_TEST_TWO |=> reg_rvalid_o && reg_rdata_o == `ORFC_RST_TEST_TWO)
        else $error("test register two read returned non-reset value");

    a_sleep_entry: assert property (
        !asleep_o && sleep_req_i |=> asleep_o)
        else $error("sleep request not taken");

    a_wake_exit: assert property (
        asleep_o && wake_i |=> !asleep_o && wake_load)
        else $error("wake not taken");

    a_test_values_hold: assert property (
        !wake_load |-> $stable(test_setting_one_o) && $stable(test_setting_two_o))
        else $error("test settings changed outside a wake");

    a_atten_holds: assert property (
        !(reg_wr_i && reg_addr_i == `ORFC_ADDR_FIFO_THR) |=> $stable(close_in_atten_o))
        else $error("attenuation changed without a write");

    c_threshold_hit: cover property (threshold_met_o && thr_q[3:0] == 4'h0);
    c_wake_retention: cover property (wake_load && thr_q[6]);
    c_pin_one_enabled: cover property ($rose(pin_one_oe_o));
    c_clock_off: cover property (sel_zero == `ORFC_SEL_XOSC_DIV ##1 sel_zero != `ORFC_SEL_XOSC_DIV);
    c_pin_zero_released: cover property ($fell(pin_zero_oe_o));
endmodule

// File: core/orfc_wake_test.sv
// Purpose: Tracks sleep and loads the internal test settings on wake
// Assumes: sleep_req_i and wake_i are single-cycle synchronous pulses
// Notes: Values live only inside the analogue side, never in the readable registers
`timescale 1ns/1ps
`include "orfc_defines.svh"
module orfc_wake_test (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic sleep_req_i,
    input wire logic wake_i,
    input wire logic retention_i,
    output logic asleep_o,
    output logic wake_load_o,
    output logic [7:0] test_one_o,
    output logic [7:0] test_two_o
);
    orfc_pkg::orfc_power_t state_q, state_d;
    logic load_q, load_d;
    logic asleep_q, asleep_d;
    logic [7:0] t1_q, t1_d, t2_q, t2_d;

    always_comb begin
        state_d = state_q;
        load_d = 1'b0;
        t1_d = t1_q;
        t2_d = t2_q;
        case (state_q)
            orfc_pkg::ORFC_ACTIVE: begin
                if (sleep_req_i) begin
                    state_d = orfc_pkg::ORFC_ASLEEP;
                end
            end
            orfc_pkg::ORFC_ASLEEP: begin
                if (wake_i) begin
                    state_d = orfc_pkg::ORFC_ACTIVE;
                    load_d = 1'b1;
                    // Retention setting is sampled as it stands at wake
                    if (retention_i) begin
                        t1_d = `ORFC_WAKE_T1_RET1;
                        t2_d = `ORFC_WAKE_T2_RET1;
                    end else begin
                        t1_d = `ORFC_WAKE_T1_RET0;
                        t2_d = `ORFC_WAKE_T2_RET0;
                    end
                end
            end
            default: begin
                state_d = orfc_pkg::ORFC_ACTIVE;
            end
        endcase
        // Power state leaves on its own flop so the pin needs no decode
        asleep_d = state_d == orfc_pkg::ORFC_ASLEEP;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= orfc_pkg::ORFC_ACTIVE;
            load_q <= 1'b0;
            asleep_q <= 1'b0;
            t1_q <= `ORFC_RST_TEST_ONE;
            t2_q <= `ORFC_RST_TEST_TWO;
        end else begin
            state_q <= state_d;
            load_q <= load_d;
            asleep_q <= asleep_d;
            t1_q <= t1_d;
            t2_q <= t2_d;
        end
    end

    assign asleep_o = asleep_q;
    assign wake_load_o = load_q;
    assign test_one_o = t1_q;
    assign test_two_o = t2_q;
endmodule

// File: tb/orfc_host_model.sv
// Purpose: Host side of the configuration port, issuing single-byte writes and reads
// Assumes: Strobes change at the falling edge, one cycle wide
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
`include "orfc_defines.svh"
module orfc_host_model (
    input wire logic sys_clk_i,
    output logic [5:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_rd_o
);
    initial begin
        reg_addr_o = 6'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge sys_clk_i);
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask
    task automatic rd(input logic [5:0] a);
        @(negedge sys_clk_i);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge sys_clk_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
    endtask
    // Moves pin zero off the divided clock early, which keeps reception clean
    task automatic quiet_pin_zero(input logic [7:0] cfg);
        wr(`ORFC_ADDR_PIN_ZERO, cfg);
    endtask
    // Sets the retention choice ahead of sleep for narrow receive filters
    task automatic set_retention(input logic ret, input logic [3:0] thr);
        wr(`ORFC_ADDR_FIFO_THR, {1'b0, ret, 2'b00, thr});
    endtask
endmodule

// File: tb/tb_orfc_regs.sv
// Purpose: Self-checking bench for the pin and threshold configuration registers
// Assumes: Divided clock shortened to 4 cycles
// Notes: Read results are checked from a queue of expected bytes
`timescale 1ns/1ps
`include "orfc_defines.svh"
module tb_orfc_regs;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [63:0] sig_src_i = 64'h0;
    logic [6:0] rx_fill_i = 7'h00;
    logic sleep_req_i = 1'b0;
    logic wake_i = 1'b0;
    logic [5:0] reg_addr_i;
    logic reg_wr_i, reg_rd_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, test_setting_one_o, test_setting_two_o;
    logic reg_rvalid_o, pin_one_o, pin_one_oe_o, pin_zero_o, pin_zero_oe_o;
    logic output_drive_strength_sel_o, threshold_met_o, asleep_o;
    logic [1:0] close_in_atten_o;
    logic [7:0] exp_q[$];
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;

    initial begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    orfc_host_model host (.sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
        .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i));

    orfc_regs #(.DIVIDE(4), .FIFO_W(7)) DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .sig_src_i(sig_src_i), .rx_fill_i(rx_fill_i), .sleep_req_i(sleep_req_i),
        .wake_i(wake_i), .pin_one_o(pin_one_o), .pin_one_oe_o(pin_one_oe_o), .pin_zero_o(pin_zero_o),
        .pin_zero_oe_o(pin_zero_oe_o), .output_drive_strength_sel_o(output_drive_strength_sel_o),
        .close_in_atten_o(close_in_atten_o), .threshold_met_o(threshold_met_o),
        .test_setting_one_o(test_setting_one_o), .test_setting_two_o(test_setting_two_o), .asleep_o(asleep_o));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic rd_exp(input logic [5:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        host.rd(a);
    endtask

    task automatic pulse(input bit to_sleep);
        @(negedge sys_clk_i);
        if (to_sleep) sleep_req_i = 1'b1;
        else wake_i = 1'b1;
        @(negedge sys_clk_i);
        sleep_req_i = 1'b0;
        wake_i = 1'b0;
    endtask

    // Read data is valid for one cycle, so it is looked at on the falling edge inside it
    always @(negedge sys_clk_i) begin
        if (reg_rvalid_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("wrong value at %0t: seen %h expected %h", $time, reg_rdata_o, 8'h00);
            end else begin
                check(reg_rdata_o, exp_q.pop_front());
            end
        end
    end

    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end

    initial begin
        logic v;
        logic [5:0] code;
        logic [7:0] t1;
        void'($urandom(30));
        repeat (10) @(negedge sys_clk_i);
        rst_i = 1'b0;
        check({7'h0, pin_one_oe_o}, 8'h00);
        // Divided clock starts low on the first edge, then toggles every two cycles
        @(negedge sys_clk_i);
        check({6'h0, pin_zero_oe_o, pin_zero_o}, 8'h02);
        for (int k = 0; k < 4; k++) begin
            repeat (2) @(negedge sys_clk_i);
            check({6'h0, pin_zero_oe_o, pin_zero_o}, {6'h0, 1'b1, ~k[0]});
        end
        rd_exp(`ORFC_ADDR_PIN_ONE, `ORFC_RST_PIN_ONE);
        rd_exp(`ORFC_ADDR_PIN_ZERO, `ORFC_RST_PIN_ZERO);
        rd_exp(`ORFC_ADDR_FIFO_THR, `ORFC_RST_FIFO_THR);
        rd_exp(6'h10, 8'h00);
        host.wr(`ORFC_ADDR_TEST_ONE, 8'h5a);
        rd_exp(`ORFC_ADDR_TEST_ONE, `ORFC_RST_TEST_ONE);
        for (int i = 0; i < 8; i++) begin
            code = 6'($urandom_range(0, 45));
            sig_src_i = {$urandom, $urandom};
            host.quiet_pin_zero({1'b0, i[0], code});
            host.wr(`ORFC_ADDR_PIN_ONE, {i[1], i[0], code});
            repeat (2) @(negedge sys_clk_i);
            check({6'h0, pin_zero_oe_o, pin_zero_o}, {6'h0, 1'b1, sig_src_i[code] ^ i[0]});
            check({6'h0, pin_one_oe_o, pin_one_o}, {6'h0, 1'b1, sig_src_i[code] ^ i[0]});
            check({7'h0, output_drive_strength_sel_o}, {7'h0, i[1]});
        end
        // Released pin zero stays low even when inverted; pin one takes the divided clock
        host.wr(`ORFC_ADDR_PIN_ZERO, {2'b01, `ORFC_SEL_THREE_STATE});
        host.wr(`ORFC_ADDR_PIN_ONE, {2'b00, `ORFC_SEL_XOSC_DIV});
        repeat (2) @(negedge sys_clk_i);
        check({6'h0, pin_zero_oe_o, pin_zero_o}, 8'h00);
        v = pin_one_o;
        repeat (2) @(negedge sys_clk_i);
        check({6'h0, pin_one_oe_o, pin_one_o}, {6'h0, 1'b1, ~v});
        for (int c = 0; c < 16; c++) begin
            host.wr(`ORFC_ADDR_FIFO_THR, {2'b00, c[1:0], c[3:0]});
            check({6'h0, close_in_atten_o}, {6'h0, c[1:0]});
            for (int d = 0; d < 2; d++) begin
                @(negedge sys_clk_i);
                rx_fill_i = 7'(4 * (c + 1) - 1 + d);
                repeat (2) @(negedge sys_clk_i);
                check({7'h0, threshold_met_o}, 8'(d));
            end
            rd_exp(`ORFC_ADDR_FIFO_THR, {2'b00, c[1:0], c[3:0]});
        end
        for (int r = 0; r < 2; r++) begin
            host.set_retention(r[0], 4'h7);
            pulse(1'b1);
            check({7'h0, asleep_o}, 8'h01);
            pulse(1'b0);
            t1 = r[0] ? `ORFC_WAKE_T1_RET1 : `ORFC_WAKE_T1_RET0;
            check({7'h0, asleep_o}, 8'h00);
            check(test_setting_one_o, t1);
            check(test_setting_two_o, r[0] ? `ORFC_WAKE_T2_RET1 : `ORFC_WAKE_T2_RET0);
            rd_exp(`ORFC_ADDR_TEST_ONE, `ORFC_RST_TEST_ONE);
            rd_exp(`ORFC_ADDR_TEST_TWO, `ORFC_RST_TEST_TWO);
        end
        repeat (3) @(negedge sys_clk_i);
        if (exp_q.size() != 0) err_count++;
        tally_and_finish();
    end
endmodule
